// file: logic/charger_pkg.sv
package charger_pkg;

	// Bus addressing and command codes
	localparam logic [6:0] DEV_ADDR = 7'h09;
	localparam logic [6:0] ALERT_ADDR = 7'h19;
	localparam logic [7:0] ALERT_REPLY = 8'h13;
	localparam logic [7:0] CMD_MODE = 8'h12;
	localparam logic [7:0] CMD_STATUS = 8'h13;
	localparam logic [7:0] CMD_CURRENT = 8'h14;
	localparam logic [7:0] CMD_VOLTAGE = 8'h15;
	localparam logic [7:0] CMD_ALARM = 8'h16;

	// Control word field positions and reset values
	localparam int MODE_INHIBIT = 0;
	localparam int MODE_POR = 2;
	localparam int MODE_BP_MASK = 5;
	localparam int MODE_PF_MASK = 6;
	localparam int MODE_OVERTEMP_HALT_ENABLE = 10;
	localparam logic RST_INHIBIT = 1'b0;
	localparam logic RST_BP_MASK = 1'b0;
	localparam logic RST_PF_MASK = 1'b1;
	localparam logic RST_OVERTEMP_HALT_ENABLE = 1'b1;

	// Alarm word bits that lock charging out
	localparam int ALARM_OVERCHARGE = 15;
	localparam int ALARM_STOP = 14;
	localparam int ALARM_OVERTEMP = 12;

	// Set point values
	localparam logic [15:0] VOLT_RESET = 16'h47F0;
	localparam logic [15:0] VOLT_MAX = 16'h47F0;
	localparam logic [15:0] VOLT_POR_CMD = 16'hFFFF;
	localparam logic [15:0] VOLT_MIN = 16'h0010;
	localparam logic [15:0] CURR_RESET = 16'h0007;
	localparam logic [15:0] CURR_DAC_MIN = 16'h0080;
	localparam int VOLT_IGNORED_BITS = 4;
	localparam int DAC_LSB = 7;
	localparam int DAC_W = 5;
	localparam logic [15:0] FS_THR_GND = 16'h0380;
	localparam logic [15:0] FS_THR_OPEN = 16'h0B80;
	localparam logic [15:0] FS_THR_RAIL = 16'h0F80;

	// Status word positions
	localparam int ST_CHG_OFF = 0;
	localparam int ST_VNOTREG = 2;
	localparam int ST_INOTREG = 3;
	localparam int ST_LEVEL2 = 4;
	localparam int ST_CURR_OR = 6;
	localparam int ST_VOLT_OR = 7;
	localparam int ST_TH_OPEN = 8;
	localparam int ST_TH_COLD = 9;
	localparam int ST_TH_HOT = 10;
	localparam int ST_TH_UR = 11;
	localparam int ST_ALARM = 12;
	localparam int ST_PFAIL = 13;
	localparam int ST_BATT = 14;
	localparam int ST_ACPRES = 15;

	typedef enum logic [1:0] {
		RANGE_GND = 2'b00,
		RANGE_OPEN = 2'b01,
		RANGE_RAIL = 2'b10
	} range_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_RACK = 3'b010,
		ST_TX = 3'b011,
		ST_TACK = 3'b100
	} bus_state_e;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b000,
		PH_CMD = 3'b001,
		PH_DLO = 3'b010,
		PH_DHI = 3'b011,
		PH_DONE = 3'b100
	} phase_e;

	// Comparator and strap levels from the analog side
	typedef struct packed {
		logic input_power;
		logic power_fail;
		logic thermal_sensor_open;
		logic thermal_sensor_cold;
		logic thermal_sensor_overheat;
		logic thermal_sensor_underrange;
		logic output_overvolt_flag;
		logic volt_loop_inactive;
		logic current_loop_inactive;
		range_e range_strap;
	} sense_s;

	// Set points and enables to the analog side
	typedef struct packed {
		logic [15:0] volt_setpoint;
		logic [4:0] current_dac_code;
		logic sw_reg_en;
		logic trickle_source;
		logic gate_hold;
	} drive_s;

	function automatic logic [4:0] full_scale_code(input range_e r);
		logic [15:0] thr;
		case (r)
			RANGE_GND: thr = FS_THR_GND;
			RANGE_OPEN: thr = FS_THR_OPEN;
			default: thr = FS_THR_RAIL;
		endcase
		return thr[DAC_LSB +: DAC_W];
	endfunction

endpackage

// file: logic/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds the second stage only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// file: logic/current_mapper.sv
`timescale 1ns/10ps
module current_mapper
	import charger_pkg::*;
(
	// Current word and strap
	input wire logic [15:0] curr_word,
	input wire range_e range_sel,
	// Decoded result
	output logic [4:0] dac_code,
	output logic over_range,
	output logic trickle_band
);
	logic [4:0] fs;
	logic [4:0] raw;

	assign fs = full_scale_code(range_sel);
	assign raw = curr_word[DAC_LSB +: DAC_W];
	// Bits above the DAC field are over range for every strap setting
	assign over_range = (|curr_word[15:DAC_LSB+DAC_W]) || (raw > fs);
	assign dac_code = over_range ? fs : raw;
	assign trickle_band = (curr_word != 16'h0000) && (curr_word < CURR_DAC_MIN);
endmodule

// file: logic/charger_smbus_ctrl.sv
`timescale 1ns/10ps
module charger_smbus_ctrl
	import charger_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Interrupt pin, open drain
	output logic alert_out,
	output logic alert_oe,
	// Analog side
	input wire sense_s sense,
	output drive_s drive
);
	localparam int SYNC_W = $bits(sense_s) + 2;

	logic scl_s, sda_s, scl_d, sda_d;
	sense_s sn;
	logic scl_rise, scl_fall, bus_start, bus_stop, byte_done, batt;

	bus_state_e state_reg;
	phase_e phase_reg, phase_next;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, cmd_reg, data_lo_reg, tx_hi_reg;
	logic tx_more_reg, go_tx_reg, ack_seen_reg, oe_reg;
	logic ack_ok, go_tx, tx_more, wr_fire, int_clr;
	logic [7:0] tx_first, tx_second;
	logic [15:0] wr_data;

	logic inhibit_reg, bp_mask_reg, pf_mask_reg, overtemp_halt_enable_reg;
	logic [15:0] volt_reg, curr_reg;
	logic alarm_reg, hot_reg, int_pend_reg;
	logic bp_d, pf_d, ac_d;
	logic [15:0] status;
	logic [15:0] volt_masked;
	logic volt_or, volt_ok, hot_halt, chg_off, charge_block;
	logic [4:0] dac;
	logic curr_or, trickle_band, sw_en;
	logic wr_mode, wr_volt, wr_curr, wr_alarm, por_wr;

	pin_sync #(.W(SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({scl_in, sda_in, sense}),
		.q({scl_s, sda_s, sn})
	);

	current_mapper u_map (
		.curr_word(curr_reg),
		.range_sel(sn.range_strap),
		.dac_code(dac),
		.over_range(curr_or),
		.trickle_band(trickle_band)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
	assign byte_done = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == 4'h8);
	assign batt = ~sn.thermal_sensor_open;

	// Byte decoder: decides acknowledge, next phase and what to send
	always_comb begin
		ack_ok = 1'b0;
		go_tx = 1'b0;
		tx_more = 1'b0;
		wr_fire = 1'b0;
		int_clr = 1'b0;
		tx_first = 8'h00;
		tx_second = 8'h00;
		phase_next = PH_DONE;
		wr_data = {shift_reg, data_lo_reg};
		if (byte_done) begin
			case (phase_reg)
				PH_ADDR: begin
					if (shift_reg == {DEV_ADDR, 1'b0}) begin
						ack_ok = 1'b1;
						phase_next = PH_CMD;
					end else if (shift_reg == {DEV_ADDR, 1'b1} &&
							cmd_reg == CMD_STATUS) begin
						ack_ok = 1'b1;
						go_tx = 1'b1;
						tx_more = 1'b1;
						tx_first = status[7:0];
						tx_second = status[15:8];
						int_clr = 1'b1;
					end else if (shift_reg == {ALERT_ADDR, 1'b1} &&
							int_pend_reg) begin
						ack_ok = 1'b1;
						go_tx = 1'b1;
						tx_first = ALERT_REPLY;
						int_clr = 1'b1;
					end
				end
				PH_CMD: begin
					if (shift_reg >= CMD_MODE && shift_reg <= CMD_ALARM) begin
						ack_ok = 1'b1;
						phase_next = PH_DLO;
					end
				end
				PH_DLO: begin
					if (cmd_reg != CMD_STATUS) begin
						ack_ok = 1'b1;
						phase_next = PH_DHI;
					end
				end
				PH_DHI: begin
					ack_ok = 1'b1;
					wr_fire = 1'b1;
				end
				default: ack_ok = 1'b0;
			endcase
		end
	end

	// Bus state machine; only ever answers, never drives a start
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			data_lo_reg <= 8'h00;
			tx_hi_reg <= 8'h00;
			tx_more_reg <= 1'b0;
			go_tx_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
			oe_reg <= 1'b0;
		end else if (bus_start) begin
			// Repeated start keeps the command for the read that follows
			state_reg <= ST_RX;
			phase_reg <= PH_ADDR;
			bit_cnt_reg <= 4'h0;
			oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RX: begin
					if (scl_rise && bit_cnt_reg != 4'h8) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						if (phase_reg == PH_CMD) begin
							cmd_reg <= shift_reg;
						end
						if (phase_reg == PH_DLO) begin
							data_lo_reg <= shift_reg;
						end
						phase_reg <= phase_next;
						go_tx_reg <= go_tx;
						tx_more_reg <= tx_more;
						tx_hi_reg <= tx_second;
						if (go_tx) begin
							shift_reg <= tx_first;
						end
						oe_reg <= ack_ok;
						state_reg <= ack_ok ? ST_RACK : ST_IDLE;
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (go_tx_reg) begin
							oe_reg <= ~shift_reg[7];
							state_reg <= ST_TX;
						end else begin
							oe_reg <= 1'b0;
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							oe_reg <= 1'b0;
							state_reg <= ST_TACK;
						end else begin
							oe_reg <= ~shift_reg[6];
							shift_reg <= {shift_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						ack_seen_reg <= ~sda_s;
					end else if (scl_fall) begin
						// High byte follows only after the master acknowledges
						if (ack_seen_reg && tx_more_reg) begin
							shift_reg <= tx_hi_reg;
							oe_reg <= ~tx_hi_reg[7];
							tx_more_reg <= 1'b0;
							bit_cnt_reg <= 4'h0;
							state_reg <= ST_TX;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;

	assign wr_mode = wr_fire && cmd_reg == CMD_MODE;
	assign wr_volt = wr_fire && cmd_reg == CMD_VOLTAGE;
	assign wr_curr = wr_fire && cmd_reg == CMD_CURRENT;
	assign wr_alarm = wr_fire && cmd_reg == CMD_ALARM;
	assign por_wr = wr_mode && wr_data[MODE_POR];

	// Control word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			inhibit_reg <= RST_INHIBIT;
			bp_mask_reg <= RST_BP_MASK;
			pf_mask_reg <= RST_PF_MASK;
			overtemp_halt_enable_reg <= RST_OVERTEMP_HALT_ENABLE;
		end else begin
			if (wr_mode) begin
				inhibit_reg <= wr_data[MODE_INHIBIT];
				bp_mask_reg <= wr_data[MODE_BP_MASK];
				pf_mask_reg <= wr_data[MODE_PF_MASK];
				overtemp_halt_enable_reg <= wr_data[MODE_OVERTEMP_HALT_ENABLE];
			end
			if (!batt) begin
				overtemp_halt_enable_reg <= RST_OVERTEMP_HALT_ENABLE;
			end
		end
	end

	// Set points; removal wins over any write in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst || !batt) begin
			volt_reg <= VOLT_RESET;
			curr_reg <= CURR_RESET;
		end else if (por_wr) begin
			volt_reg <= VOLT_POR_CMD;
			curr_reg <= CURR_RESET;
		end else begin
			if (wr_volt) begin
				volt_reg <= wr_data;
			end
			if (wr_curr) begin
				curr_reg <= wr_data;
			end
		end
	end

	// Latched flags; a hot reading wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alarm_reg <= 1'b0;
			hot_reg <= 1'b0;
		end else begin
			if (!batt || por_wr || wr_volt || wr_curr) begin
				alarm_reg <= 1'b0;
			end else if (wr_alarm && (wr_data[ALARM_OVERCHARGE] ||
					wr_data[ALARM_STOP] || wr_data[ALARM_OVERTEMP])) begin
				alarm_reg <= 1'b1;
			end
			if (sn.thermal_sensor_overheat) begin
				hot_reg <= 1'b1;
			end else if (!batt || por_wr) begin
				hot_reg <= 1'b0;
			end
		end
	end

	// Interrupt; pending from reset since the block powers up with input power
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bp_d <= 1'b0;
			pf_d <= 1'b0;
			ac_d <= 1'b0;
			int_pend_reg <= 1'b1;
		end else begin
			bp_d <= batt;
			pf_d <= sn.power_fail;
			ac_d <= sn.input_power;
			if ((sn.input_power && !ac_d) ||
					((batt ^ bp_d) && !bp_mask_reg) ||
					((sn.power_fail ^ pf_d) && !pf_mask_reg)) begin
				int_pend_reg <= 1'b1;
			end else if (int_clr) begin
				int_pend_reg <= 1'b0;
			end
		end
	end

	assign alert_out = 1'b0;
	assign alert_oe = int_pend_reg;

	// Charger decisions
	assign volt_masked = {volt_reg[15:VOLT_IGNORED_BITS],
		{VOLT_IGNORED_BITS{1'b0}}};
	assign volt_or = volt_masked > VOLT_MAX;
	assign volt_ok = volt_masked >= VOLT_MIN;
	assign hot_halt = hot_reg && overtemp_halt_enable_reg &&
		!sn.thermal_sensor_underrange;
	assign chg_off = inhibit_reg || hot_halt;
	assign charge_block = chg_off || alarm_reg || !volt_ok;
	assign sw_en = !charge_block && dac != 5'h00;

	always_comb begin
		status = 16'h0000;
		status[ST_CHG_OFF] = chg_off;
		status[ST_VNOTREG] = sn.volt_loop_inactive;
		status[ST_INOTREG] = sn.current_loop_inactive;
		status[ST_LEVEL2] = 1'b1;
		status[ST_CURR_OR] = curr_or;
		status[ST_VOLT_OR] = volt_or;
		status[ST_TH_OPEN] = sn.thermal_sensor_open;
		status[ST_TH_COLD] = sn.thermal_sensor_cold;
		status[ST_TH_HOT] = hot_reg;
		status[ST_TH_UR] = sn.thermal_sensor_underrange;
		status[ST_ALARM] = alarm_reg;
		status[ST_PFAIL] = sn.power_fail;
		status[ST_BATT] = batt;
		status[ST_ACPRES] = sn.input_power;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			drive <= '{volt_setpoint: VOLT_RESET, current_dac_code: 5'h00,
				sw_reg_en: 1'b0, trickle_source: 1'b0, gate_hold: 1'b1};
		end else begin
			drive.volt_setpoint <= volt_or ? VOLT_MAX : volt_masked;
			drive.current_dac_code <= sw_en ? dac : 5'h00;
			drive.sw_reg_en <= sw_en;
			drive.trickle_source <= !charge_block && trickle_band &&
				!sn.output_overvolt_flag;
			drive.gate_hold <= !sw_en;
		end
	end
endmodule

// file: verif/charger_properties.sv
`timescale 1ns/10ps
module charger_properties
	import charger_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bus and interrupt pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alert_out,
	input wire logic alert_oe,
	// Analog side
	input wire sense_s sense,
	input wire drive_s drive
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [4:0] fs;
	// Own copy of the full-scale codes, not the design's helper
	always_comb begin
		case (sense.range_strap)
			RANGE_GND: fs = 5'h07;
			RANGE_OPEN: fs = 5'h17;
			default: fs = 5'h1F;
		endcase
	end
	gate_hold_a: assert property (drive.gate_hold == !drive.sw_reg_en)
		else $error("gate hold wrong");
	reg_enable_a: assert property (
		drive.sw_reg_en == (drive.current_dac_code != 5'h00))
		else $error("regulator enable wrong");
	fs_clamp_a: assert property (
		$stable(sense.range_strap) [*8] |-> drive.current_dac_code <= fs)
		else $error("dac above full scale");
	trickle_excl_a: assert property (
		drive.trickle_source |-> drive.current_dac_code == 5'h00)
		else $error("trickle with dac");
	overvolt_a: assert property (
		sense.output_overvolt_flag [*8] |-> !drive.trickle_source)
		else $error("trickle under overvoltage");
	volt_range_a: assert property (
		drive.volt_setpoint <= VOLT_MAX && drive.volt_setpoint[3:0] == 4'h0)
		else $error("voltage set point out of range");
	absent_reset_a: assert property (
		sense.thermal_sensor_open [*8] |->
		drive.volt_setpoint == VOLT_RESET && drive.current_dac_code == 5'h00)
		else $error("set points kept without battery");
	sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved while clock high");
	open_drain_a: assert property (!sda_out && !alert_out)
		else $error("open drain pin driven high");
	power_alert_a: assert property (
		$rose(sense.input_power) |-> ##[1:8] alert_oe)
		else $error("no interrupt on power");
	alert_clear_a: assert property ($fell(alert_oe) |-> ##[0:8] sda_oe)
		else $error("interrupt cleared without ack");
	cover property (drive.sw_reg_en && drive.current_dac_code == fs);
	cover property ($fell(alert_oe));
	cover property (drive.trickle_source);
endmodule

bind charger_smbus_ctrl charger_properties chk_u (
	.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
	.alert_oe(alert_oe), .sense(sense), .drive(drive)
);

// file: verif/smbus_host.sv
`timescale 1ns/10ps
module smbus_host
	import charger_pkg::*;
(
	// Bus pins, SDA open drain with pull-up
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// SDA moves only while SCL is low; 80 ns bit period
	task automatic bit_x(input logic b, output logic r);
		#13 sda_low = ~b;
		#37 scl = 1'b1;
		r = sda;
		#30 scl = 1'b0;
	endtask
	task automatic start_c;
		#13 sda_low = 1'b0;
		#27 scl = 1'b1;
		#40 sda_low = 1'b1;
		#40 scl = 1'b0;
	endtask
	task automatic stop_c;
		#13 sda_low = 1'b1;
		#37 scl = 1'b1;
		#40 sda_low = 1'b0;
		#40;
	endtask
	task automatic tx(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ok = ok & ~r;
	endtask
	task automatic rx(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(nak, r);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] d, output logic ok);
		ok = 1'b1;
		start_c();
		tx({a, 1'b0}, ok);
		tx(c, ok);
		tx(d[7:0], ok);
		tx(d[15:8], ok);
		stop_c();
	endtask
	task automatic rd(output logic [15:0] d, output logic ok);
		ok = 1'b1;
		start_c();
		tx({DEV_ADDR, 1'b0}, ok);
		tx(CMD_STATUS, ok);
		start_c();
		tx({DEV_ADDR, 1'b1}, ok);
		rx(1'b0, d[7:0]);
		rx(1'b1, d[15:8]);
		stop_c();
	endtask
	task automatic ara(output logic [7:0] d, output logic ok);
		ok = 1'b1;
		start_c();
		tx({ALERT_ADDR, 1'b1}, ok);
		rx(1'b1, d);
		stop_c();
	endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import charger_pkg::*;
;
	localparam logic [15:0] MODE_BASE = 16'hFF90;
	logic clk_sys, rst, scl, sda_low, sda_line;
	logic sda_out, sda_oe, alert_out, alert_oe, ok;
	logic [15:0] st, v;
	logic [7:0] rb;
	logic [15:0] cc [5] = '{16'h0000, 16'h0007, 16'h007F, 16'h0080,
		16'hFFFF};
	sense_s sense;
	drive_s drive;
	int num_errors = 0;
	int total_checks = 0;
	assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
	charger_smbus_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .sense(sense),
		.drive(drive));
	smbus_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda_line));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic tend(input string n);
		$display("test %s ended, mismatches %0d", n, num_errors);
	endtask
	// Synchronisers need a few cycles before outputs follow inputs
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic w(input logic [7:0] c, input logic [15:0] d);
		host_u.wr(DEV_ADDR, c, d, ok);
		chk("ack", ok, 1'b1);
	endtask
	function automatic logic [4:0] fsx(input range_e r);
		return (r == RANGE_GND) ? 5'h07 : (r == RANGE_OPEN) ? 5'h17 : 5'h1F;
	endfunction
	task automatic cur(input logic [15:0] c);
		logic [4:0] d;
		logic orng;
		orng = c[15:7] > {4'h0, fsx(sense.range_strap)};
		d = orng ? fsx(sense.range_strap) : c[11:7];
		w(CMD_CURRENT, c);
		chk("dac", drive.current_dac_code, d);
		chk("reg", drive.sw_reg_en, d != 5'h00);
		chk("gate", drive.gate_hold, d == 5'h00);
		chk("trk", drive.trickle_source, d == 5'h00 && c != 0);
		host_u.rd(st, ok);
		chk("cur_or", st[ST_CURR_OR], orng);
	endtask
	initial begin
		#900000;
		num_errors++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		sense = '0;
		sense.input_power = 1'b1;
		sense.range_strap = RANGE_RAIL;
		void'($urandom(32'h9350E15A));
		repeat (12) @(posedge clk_sys);
		#2 rst = 1'b0;
		cyc(8);
		chk("alert", alert_oe, 1'b1);
		chk("volt", drive.volt_setpoint, VOLT_RESET);
		chk("trk", drive.trickle_source, 1'b1);
		host_u.rd(st, ok);
		chk("status", st, 16'hC010);
		chk("alert_clr", alert_oe, 1'b0);
		tend("reset");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 16'h47F0 : (i == 1) ? 16'h4800 : 16'($urandom);
			w(CMD_VOLTAGE, v);
			chk("volt", drive.volt_setpoint,
				v > VOLT_MAX ? VOLT_MAX : {v[15:4], 4'h0});
			host_u.rd(st, ok);
			if (v[15:4] != 12'h47F) begin
				chk("volt_or", st[ST_VOLT_OR], v > VOLT_MAX);
			end
		end
		w(CMD_VOLTAGE, 16'h3000);
		tend("voltage");
		for (int r = 0; r < 3; r++) begin
			sense.range_strap = range_e'(r);
			cyc(8);
			for (int i = 0; i < 9; i++) begin
				v = {4'h0, fsx(range_e'(r)), 7'h00};
				v = (i == 6) ? v + 16'h0080 : v;
				v = (i < 5) ? cc[i] : v;
				v = (i > 6) ? 16'($urandom) & 16'h1FFF : v;
				cur(v);
			end
		end
		cur(16'h0007);
		sense.output_overvolt_flag = 1'b1;
		cyc(8);
		chk("trk_ov", drive.trickle_source, 1'b0);
		sense.output_overvolt_flag = 1'b0;
		tend("current");
		for (int i = 0; i < 4; i++) begin
			w(CMD_CURRENT, 16'h0200);
			w(CMD_ALARM, 16'h1000 << i);
			chk("dac_lk", drive.current_dac_code, i == 1 ? 5'h04 : 5'h00);
			host_u.rd(st, ok);
			chk("lock", st[ST_ALARM], i != 1);
		end
		w(CMD_CURRENT, 16'h0200);
		chk("dac_unlk", drive.current_dac_code, 5'h04);
		tend("alarm");
		w(CMD_MODE, MODE_BASE | 16'h0001);
		chk("dac_inh", drive.current_dac_code, 5'h00);
		host_u.rd(st, ok);
		chk("inh", st[ST_CHG_OFF], 1'b1);
		w(CMD_MODE, MODE_BASE);
		chk("dac_run", drive.current_dac_code, 5'h04);
		w(CMD_ALARM, 16'h8000);
		w(CMD_MODE, MODE_BASE | 16'h0004);
		chk("volt_por", drive.volt_setpoint, VOLT_MAX);
		chk("trk_por", drive.trickle_source, 1'b1);
		sense.thermal_sensor_overheat = 1'b1;
		cyc(8);
		host_u.rd(st, ok);
		chk("hot", st[ST_TH_HOT], 1'b1);
		chk("hot_off", st[ST_CHG_OFF], 1'b1);
		w(CMD_MODE, MODE_BASE & 16'hFBFF);
		chk("hot_run", drive.trickle_source, 1'b1);
		tend("mode");
		w(CMD_VOLTAGE, 16'h2000);
		w(CMD_CURRENT, 16'h0400);
		sense.thermal_sensor_open = 1'b1;
		cyc(8);
		chk("volt_rm", drive.volt_setpoint, VOLT_RESET);
		chk("dac_rm", drive.current_dac_code, 5'h00);
		chk("alert_rm", alert_oe, 1'b1);
		sense.thermal_sensor_open = 1'b0;
		cyc(8);
		host_u.rd(st, ok);
		chk("hot_ins", st[ST_CHG_OFF], 1'b1);
		chk("trk_ins", drive.trickle_source, 1'b0);
		tend("removal");
		sense.power_fail = 1'b1;
		cyc(8);
		chk("alert_pf", alert_oe, 1'b1);
		host_u.ara(rb, ok);
		chk("reply", rb, ALERT_REPLY);
		chk("alert_ara", alert_oe, 1'b0);
		w(CMD_MODE, MODE_BASE | 16'h0060);
		sense.power_fail = 1'b0;
		sense.thermal_sensor_open = 1'b1;
		cyc(8);
		chk("alert_msk", alert_oe, 1'b0);
		host_u.ara(rb, ok);
		chk("ara_nak", ok, 1'b0);
		sense.thermal_sensor_open = 1'b0;
		sense.input_power = 1'b0;
		cyc(8);
		sense.input_power = 1'b1;
		cyc(8);
		chk("alert_pw", alert_oe, 1'b1);
		tend("interrupt");
		w(CMD_VOLTAGE, 16'h1000);
		host_u.wr(7'h0A, CMD_VOLTAGE, 16'h2000, ok);
		chk("addr_nak", ok, 1'b0);
		chk("volt_keep", drive.volt_setpoint, 16'h1000);
		tend("address");
		// Underrange reading must override the hot halt
		sense.thermal_sensor_underrange = 1'b1;
		sense.thermal_sensor_cold = 1'b1;
		sense.volt_loop_inactive = 1'b1;
		sense.current_loop_inactive = 1'b1;
		cyc(8);
		host_u.rd(st, ok);
		chk("st_therm", st[ST_TH_UR:ST_TH_OPEN], 4'hE);
		chk("st_loop", st[ST_INOTREG:ST_VNOTREG], 2'h3);
		chk("ur_run", st[ST_CHG_OFF], 1'b0);
		tend("status");
		final_report();
	end
endmodule
